// ==== core/peu_pkg.sv ====
// Package: encodings, field positions and result layout of the precision expand unit
package peu_pkg;

  // ************************************************************
  // Instruction word fields
  // ************************************************************
  localparam int          PEU_OP_HI      = 31;
  localparam int          PEU_OP_LO      = 26;
  localparam int          PEU_RS_HI      = 25;
  localparam int          PEU_RS_LO      = 21;
  localparam int          PEU_SRC_HI     = 20;
  localparam int          PEU_SRC_LO     = 16;
  localparam int          PEU_DST_HI     = 15;
  localparam int          PEU_DST_LO     = 11;
  localparam int          PEU_SUB_HI     = 10;
  localparam int          PEU_SUB_LO     = 6;
  localparam int          PEU_FN_HI      = 5;
  localparam int          PEU_FN_LO      = 0;

  // ************************************************************
  // Encodings
  // ************************************************************
  localparam logic [5:0]  PEU_EXT_MAJOR  = 6'h1f;
  localparam logic [4:0]  PEU_RS_ZERO    = 5'h00;
  localparam logic [5:0]  PEU_FN_PAIRED  = 6'h12;
  localparam logic [5:0]  PEU_FN_QUAD    = 6'h16;
  localparam logic [4:0]  PEU_SUB_HW_L   = 5'h0c;
  localparam logic [4:0]  PEU_SUB_HW_R   = 5'h0d;
  localparam logic [4:0]  PEU_SUB_BP_L   = 5'h04;
  localparam logic [4:0]  PEU_SUB_BP_R   = 5'h05;
  localparam logic [4:0]  PEU_SUB_BP_LA  = 5'h06;
  localparam logic [4:0]  PEU_SUB_BP_RA  = 5'h07;
  localparam logic [4:0]  PEU_SUB_BQ_L   = 5'h04;

  // ************************************************************
  // Padding widths
  // ************************************************************
  localparam int          PEU_HW_PAD     = 16;
  localparam int          PEU_BYTE_PAD   = 7;
  localparam int          PEU_SEXT_W     = 32;

  // ************************************************************
  // Operation select
  // ************************************************************
  typedef enum logic [2:0] {
    PEU_OP_NONE,
    PEU_OP_HW_L,
    PEU_OP_HW_R,
    PEU_OP_BP_L,
    PEU_OP_BP_LA,
    PEU_OP_BP_R,
    PEU_OP_BP_RA,
    PEU_OP_BQ_L
  } peu_op_t;

endpackage

// ==== core/peu_decode.sv ====
// Decoder: turns an instruction word into an expansion operation select
`timescale 1ns/1ns
module peu_decode
  import peu_pkg::*;
(
  // Instruction
  input  wire logic [31:0] instr,
  // Decoded operation
  output peu_op_t          op,
  output logic      [4:0]  src_idx,
  output logic      [4:0]  dst_idx
);

  logic      [5:0] major;
  logic      [4:0] rs_field;
  logic      [4:0] sub_op;
  logic      [5:0] fn_code;
  logic            class_ok;

  assign major    = instr[PEU_OP_HI:PEU_OP_LO];
  assign rs_field = instr[PEU_RS_HI:PEU_RS_LO];
  assign sub_op   = instr[PEU_SUB_HI:PEU_SUB_LO];
  assign fn_code  = instr[PEU_FN_HI:PEU_FN_LO];
  assign src_idx  = instr[PEU_SRC_HI:PEU_SRC_LO];
  assign dst_idx  = instr[PEU_DST_HI:PEU_DST_LO];
  assign class_ok = (major == PEU_EXT_MAJOR) && (rs_field == PEU_RS_ZERO);

  always_comb begin
    op = PEU_OP_NONE;
    if (class_ok && fn_code == PEU_FN_PAIRED) begin
      unique case (sub_op)
        PEU_SUB_HW_L:  op = PEU_OP_HW_L;
        PEU_SUB_HW_R:  op = PEU_OP_HW_R;
        PEU_SUB_BP_L:  op = PEU_OP_BP_L;
        PEU_SUB_BP_LA: op = PEU_OP_BP_LA;
        PEU_SUB_BP_R:  op = PEU_OP_BP_R;
        PEU_SUB_BP_RA: op = PEU_OP_BP_RA;
        default:       op = PEU_OP_NONE;
      endcase
    end else if (class_ok && fn_code == PEU_FN_QUAD && sub_op == PEU_SUB_BQ_L) begin
      op = PEU_OP_BQ_L;
    end
  end

endmodule

// ==== core/peu_select.sv ====
// Element selection and zero padding for every expansion operation
`timescale 1ns/1ns
module peu_select
  import peu_pkg::*;
(
  // Operation and operand
  input  peu_op_t          op,
  input  wire logic [63:0] src,
  // Result
  output logic      [63:0] result
);

  // Unsigned byte to Q15: zero sign bit, byte, seven zeros
  function automatic logic [15:0] byte_q15(input logic [7:0] b);
    byte_q15 = {1'b0, b, {PEU_BYTE_PAD{1'b0}}};
  endfunction

  // Q15 halfword to Q31 word, sign-extended to 64 bits
  function automatic logic [63:0] half_q31(input logic [15:0] h);
    logic [31:0] w;
    w        = {h, {PEU_HW_PAD{1'b0}}};
    half_q31 = {{PEU_SEXT_W{w[31]}}, w};
  endfunction

  // Two Q15 results, upper one sign-extended
  function automatic logic [63:0] pair_q15(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] u;
    u        = byte_q15(hi);
    pair_q15 = {{PEU_SEXT_W{u[15]}}, u, byte_q15(lo)};
  endfunction

  // Pure wiring, no carries: one-pass combinational result
  always_comb begin
    unique case (op)
      PEU_OP_HW_L:  result = half_q31(src[31:16]);
      PEU_OP_HW_R:  result = half_q31(src[15:0]);
      PEU_OP_BP_L:  result = pair_q15(src[31:24], src[23:16]);
      PEU_OP_BP_LA: result = pair_q15(src[31:24], src[15:8]);
      PEU_OP_BP_R:  result = pair_q15(src[15:8], src[7:0]);
      PEU_OP_BP_RA: result = pair_q15(src[23:16], src[7:0]);
      PEU_OP_BQ_L:  result = {byte_q15(src[63:56]), byte_q15(src[55:48]),
                              byte_q15(src[47:40]), byte_q15(src[39:32])};
      default:      result = 64'h0;
    endcase
  end

endmodule

// ==== core/peu_top.sv ====
// Precision expand unit: decode, read operand, expand, register write-back
//
// Behaviour
// - Left halfword expansion uses source bits 31..16.
// - Right halfword expansion uses source bits 15..0.
// - Halfword becomes Q31 with sixteen zero bits appended below.
// - Q31 bit 31 fills destination bits 63..32.
// - Byte becomes Q15: zero sign bit, byte, seven low zeros.
// - Left pair takes bytes 31..24 and 23..16.
// - Left-alternate pair takes bytes 31..24 and 15..8.
// - Right pair takes bytes 15..8 and 7..0.
// - Right-alternate pair takes bytes 23..16 and 7..0.
// - Pair results fill bits 31..0; upper result top bit fills 63..32.
// - No data-dependent exception is ever raised.
// - Only reserved-instruction and extension-disabled exceptions may be raised; exc_reserved_r is tied to zero, so only extension-disabled is raised.
// - Opcode 011111, zero field bits 25..21; source 20..16, destination 15..11.
// - Function 010010: sub-op 01100 left, 01101 right halfword expansion.
// - Function 010010: sub-op 00100 left pair, 00110 left-alternate pair.
// - Function 010010: sub-op 00101 right pair, 00111 right-alternate pair.
// - Function 010110 with sub-op 00100 selects quad left byte expansion.
// - Quad left expands bytes 63..32, most significant first.
`timescale 1ns/1ns
module peu_top
  import peu_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Issue from the decoder
  input  wire logic        issue_valid,
  input  wire logic [31:0] issue_instr,
  input  wire logic        ext_enable,
  // General register file read port
  output logic      [4:0]  rf_rd_idx,
  input  wire logic [63:0] rf_rd_data,
  // General register file write-back
  output logic             wb_valid_r,
  output logic      [4:0]  wb_idx_r,
  output logic      [63:0] wb_data_r,
  // Exceptions
  output logic             exc_reserved_r,
  output logic             exc_disabled_r
);

  // ************************************************************
  // Decode
  // ************************************************************
  peu_op_t          op;
  logic      [4:0]  src_idx;
  logic      [4:0]  dst_idx;
  logic      [63:0] result;
  logic             is_expand;
  logic             do_write;
  logic             raise_disabled;
  logic             raise_reserved;

  peu_decode u_decode (
    .instr   (issue_instr),
    .op      (op),
    .src_idx (src_idx),
    .dst_idx (dst_idx)
  );

  // Register file read is combinational; the read index is the only output
  // not taken from a flip-flop because the operand is needed in the same cycle.
  assign rf_rd_idx = src_idx;

  peu_select u_select (
    .op     (op),
    .src    (rf_rd_data),
    .result (result)
  );

  // ************************************************************
  // Exception and write-back qualification
  // ************************************************************
  // Exceptions depend only on the decoded instruction, issue_valid and enable, never on operand data.
  assign is_expand      = (op != PEU_OP_NONE);
  assign raise_disabled = issue_valid && is_expand && !ext_enable;
  assign raise_reserved = 1'b0;
  assign do_write       = issue_valid && is_expand && ext_enable;

  // ************************************************************
  // Write-back registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_valid_r     <= 1'b0;
      wb_idx_r       <= 5'h00;
      wb_data_r      <= 64'h0;
      exc_reserved_r <= 1'b0;
      exc_disabled_r <= 1'b0;
    end else begin
      wb_valid_r     <= do_write;
      wb_idx_r       <= dst_idx;
      wb_data_r      <= result;
      exc_reserved_r <= raise_reserved;
      exc_disabled_r <= raise_disabled;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_hw_left;
    @(posedge mclk) disable iff (rst)
      (do_write && op == PEU_OP_HW_L) |=> (wb_data_r ==
        {{32{$past(rf_rd_data[31])}}, $past(rf_rd_data[31:16]), 16'h0});
  endproperty
  a_hw_left: assert property (p_hw_left) else $error("left half expand wrong");

  property p_hw_right;
    @(posedge mclk) disable iff (rst)
      (do_write && op == PEU_OP_HW_R) |=> (wb_data_r[31:0] ==
        {$past(rf_rd_data[15:0]), 16'h0});
  endproperty
  a_hw_right: assert property (p_hw_right) else $error("right half expand wrong");

  property p_low_zero;
    @(posedge mclk) disable iff (rst)
      (do_write && (op == PEU_OP_HW_L || op == PEU_OP_HW_R)) |=> (wb_data_r[15:0] == 16'h0);
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low pad not zero");

  property p_sext;
    @(posedge mclk) disable iff (rst)
      wb_valid_r && (wb_data_r[31] == 1'b0) && ($past(op) == PEU_OP_HW_L ||
        $past(op) == PEU_OP_HW_R) |-> (wb_data_r[63:32] == 32'h0);
  endproperty
  a_sext: assert property (p_sext) else $error("sign extension wrong");

  property p_byte_fmt;
    @(posedge mclk) disable iff (rst)
      (do_write && op == PEU_OP_BQ_L) |=> (wb_data_r[15] == 1'b0) && (wb_data_r[6:0] == 7'h0);
  endproperty
  a_byte_fmt: assert property (p_byte_fmt) else $error("byte format wrong");

  property p_pair_left;
    @(posedge mclk) disable iff (rst)
      (do_write && op == PEU_OP_BP_L) |=> (wb_data_r ==
        {32'h0, 1'b0, $past(rf_rd_data[31:24]), 7'h0, 1'b0, $past(rf_rd_data[23:16]), 7'h0});
  endproperty
  a_pair_left: assert property (p_pair_left) else $error("left pair wrong");

  property p_pair_la;
    @(posedge mclk) disable iff (rst)
      (do_write && op == PEU_OP_BP_LA) |=> (wb_data_r[14:7] == $past(rf_rd_data[15:8]));
  endproperty
  a_pair_la: assert property (p_pair_la) else $error("left-alt pair wrong");

  property p_pair_r;
    @(posedge mclk) disable iff (rst)
      (do_write && op == PEU_OP_BP_R) |=> (wb_data_r[30:23] == $past(rf_rd_data[15:8])) &&
        (wb_data_r[14:7] == $past(rf_rd_data[7:0]));
  endproperty
  a_pair_r: assert property (p_pair_r) else $error("right pair wrong");

  property p_pair_ra;
    @(posedge mclk) disable iff (rst)
      (do_write && op == PEU_OP_BP_RA) |=> (wb_data_r[30:23] == $past(rf_rd_data[23:16]));
  endproperty
  a_pair_ra: assert property (p_pair_ra) else $error("right-alt pair wrong");

  property p_pair_top;
    @(posedge mclk) disable iff (rst)
      (do_write && (op == PEU_OP_BP_R || op == PEU_OP_BP_RA)) |=> (wb_data_r[63:31] == 33'h0);
  endproperty
  a_pair_top: assert property (p_pair_top) else $error("pair upper bits wrong");

  property p_no_reserved;
    @(posedge mclk) disable iff (rst)
      wb_valid_r |-> !exc_reserved_r && !exc_disabled_r;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("exception with write");

  property p_disabled;
    @(posedge mclk) disable iff (rst)
      (issue_valid && is_expand && !ext_enable) |=> exc_disabled_r && !wb_valid_r;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled exception missing");

  property p_decode;
    @(posedge mclk) disable iff (rst)
      (issue_valid && ext_enable && issue_instr[31:26] == 6'h1f && issue_instr[25:21] == 5'h00
        && issue_instr[5:0] == 6'h12 && issue_instr[10:6] == 5'h0c)
        |=> wb_valid_r && (wb_idx_r == $past(issue_instr[15:11]));
  endproperty
  a_decode: assert property (p_decode) else $error("decode failed");

  property p_rs_nonzero;
    @(posedge mclk) disable iff (rst)
      (issue_instr[25:21] != 5'h00) |-> (op == PEU_OP_NONE);
  endproperty
  a_rs_nonzero: assert property (p_rs_nonzero) else $error("nonzero rs decoded");

  property p_sub_r;
    @(posedge mclk) disable iff (rst)
      (issue_instr[31:21] == 11'h3e0 && issue_instr[5:0] == 6'h12
        && issue_instr[10:6] == 5'h0d) |-> (op == PEU_OP_HW_R);
  endproperty
  a_sub_r: assert property (p_sub_r) else $error("right half not decoded");

  property p_sub_la;
    @(posedge mclk) disable iff (rst)
      (issue_instr[31:21] == 11'h3e0 && issue_instr[5:0] == 6'h12
        && issue_instr[10:6] == 5'h06) |-> (op == PEU_OP_BP_LA);
  endproperty
  a_sub_la: assert property (p_sub_la) else $error("left-alt not decoded");

  property p_sub_ra;
    @(posedge mclk) disable iff (rst)
      (issue_instr[31:21] == 11'h3e0 && issue_instr[5:0] == 6'h12
        && issue_instr[10:6] == 5'h07) |-> (op == PEU_OP_BP_RA);
  endproperty
  a_sub_ra: assert property (p_sub_ra) else $error("right-alt not decoded");

  property p_quad_dec;
    @(posedge mclk) disable iff (rst)
      (issue_instr[31:21] == 11'h3e0 && issue_instr[5:0] == 6'h16
        && issue_instr[10:6] == 5'h04) |-> (op == PEU_OP_BQ_L);
  endproperty
  a_quad_dec: assert property (p_quad_dec) else $error("quad not decoded");

  property p_quad;
    @(posedge mclk) disable iff (rst)
      (do_write && op == PEU_OP_BQ_L) |=> (wb_data_r[62:55] == $past(rf_rd_data[63:56])) &&
        (wb_data_r[14:7] == $past(rf_rd_data[39:32]));
  endproperty
  a_quad: assert property (p_quad) else $error("quad expand wrong");

  property p_one_op;
    @(posedge mclk) disable iff (rst)
      do_write |=> wb_valid_r ##1 (wb_valid_r == $past(do_write));
  endproperty
  a_one_op: assert property (p_one_op) else $error("write-back not single cycle");

endmodule

// ==== verification/peu_rf_model.sv ====
// Register file model on the far side of the precision expand unit
`timescale 1ns/1ns
module peu_rf_model (
  // Clock
  input  wire logic        mclk,
  // Read port
  input  wire logic [4:0]  rd_idx,
  output logic      [63:0] rd_data,
  // Write-back port
  input  wire logic        wb_valid,
  input  wire logic [4:0]  wb_idx,
  input  wire logic [63:0] wb_data
);
  logic [63:0] mem [32];

  // Read is combinational: the unit samples its operand in the issue cycle
  assign rd_data = mem[rd_idx];

  // The whole 64-bit result lands in one write
  always @(posedge mclk) begin
    if (wb_valid) begin
      mem[wb_idx] <= wb_data;
    end
  end
endmodule

// ==== verification/testbench.sv ====
// Self-checking testbench of the precision expand unit
`timescale 1ns/1ns
module testbench;
  import peu_pkg::*;
  logic        mclk;
  logic        rst;
  logic        issue_valid;
  logic        ext_enable;
  logic [31:0] issue_instr;
  logic [4:0]  rf_rd_idx;
  logic [4:0]  wb_idx_r;
  logic [63:0] rf_rd_data;
  logic [63:0] wb_data_r;
  logic        wb_valid_r;
  logic        exc_reserved_r;
  logic        exc_disabled_r;
  int          error_cnt = 0;
  int          comparisons = 0;
  // Sign bits of both halfword and byte lanes differ between the two operands
  localparam logic [63:0] SRC_A = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] SRC_B = 64'hfedc_ba98_7654_3210;

  peu_top DUT (.mclk(mclk), .rst(rst), .issue_valid(issue_valid), .issue_instr(issue_instr),
    .ext_enable(ext_enable), .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data),
    .wb_valid_r(wb_valid_r), .wb_idx_r(wb_idx_r), .wb_data_r(wb_data_r),
    .exc_reserved_r(exc_reserved_r), .exc_disabled_r(exc_disabled_r));

  peu_rf_model rf (.mclk(mclk), .rd_idx(rf_rd_idx), .rd_data(rf_rd_data),
    .wb_valid(wb_valid_r), .wb_idx(wb_idx_r), .wb_data(wb_data_r));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] q15(input logic [7:0] b);
    return {1'b0, b, 7'h00};
  endfunction

  // Encodings written out literally so a wrong package constant cannot hide
  function automatic logic [31:0] mk(input logic [5:0] fn, input logic [4:0] sub,
                                     input logic [4:0] s, input logic [4:0] d);
    return {6'h1f, 5'h00, s, d, sub, fn};
  endfunction

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One issue cycle, then the write-back cycle is judged
  task automatic do_op(input logic [31:0] instr, input logic en, input logic wb_exp,
                       input logic dis_exp, input logic [63:0] data_exp);
    @(posedge mclk);
    issue_valid <= 1'b1;
    issue_instr <= instr;
    ext_enable  <= en;
    #1;
    chk("rf_rd_idx", {59'h0, instr[20:16]}, {59'h0, rf_rd_idx});
    @(posedge mclk);
    issue_valid <= 1'b0;
    ext_enable  <= 1'b1;
    #1;
    chk("wb_valid_r", {63'h0, wb_exp}, {63'h0, wb_valid_r});
    chk("exc_disabled_r", {63'h0, dis_exp}, {63'h0, exc_disabled_r});
    chk("exc_reserved_r", 64'h0, {63'h0, exc_reserved_r});
    if (wb_exp) begin
      chk("wb_idx_r", {59'h0, instr[15:11]}, {59'h0, wb_idx_r});
      chk("wb_data_r", data_exp, wb_data_r);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("reset wb_valid_r", 64'h0, {63'h0, wb_valid_r});
    chk("reset wb_data_r", 64'h0, wb_data_r);
    chk("reset exc", 64'h0, {62'h0, exc_reserved_r, exc_disabled_r});
  endtask

  task automatic t_half();
    rf.mem[3] = SRC_A;
    rf.mem[4] = SRC_B;
    do_op(mk(6'h12, 5'h0c, 5'd3, 5'd7), 1, 1, 0, 64'hffff_ffff_89ab_0000);
    do_op(mk(6'h12, 5'h0d, 5'd3, 5'd31), 1, 1, 0, 64'hffff_ffff_cdef_0000);
    do_op(mk(6'h12, 5'h0c, 5'd4, 5'd0), 1, 1, 0, 64'h0000_0000_7654_0000);
    do_op(mk(6'h12, 5'h0d, 5'd4, 5'd9), 1, 1, 0, 64'h0000_0000_3210_0000);
  endtask

  // Byte sign bits are set in SRC_A, yet the upper half must stay zero
  task automatic t_pair();
    do_op(mk(6'h12, 5'h04, 5'd3, 5'd11), 1, 1, 0,
          {32'h0, q15(SRC_A[31:24]), q15(SRC_A[23:16])});
    do_op(mk(6'h12, 5'h06, 5'd3, 5'd12), 1, 1, 0,
          {32'h0, q15(SRC_A[31:24]), q15(SRC_A[15:8])});
    do_op(mk(6'h12, 5'h05, 5'd3, 5'd13), 1, 1, 0,
          {32'h0, q15(SRC_A[15:8]), q15(SRC_A[7:0])});
    do_op(mk(6'h12, 5'h07, 5'd4, 5'd14), 1, 1, 0,
          {32'h0, q15(SRC_B[23:16]), q15(SRC_B[7:0])});
  endtask

  task automatic t_quad();
    do_op(mk(6'h16, 5'h04, 5'd4, 5'd15), 1, 1, 0, {q15(SRC_B[63:56]), q15(SRC_B[55:48]),
          q15(SRC_B[47:40]), q15(SRC_B[39:32])});
  endtask

  // Disabled extension, bad fields and unsupported sub-operations
  task automatic t_refuse();
    do_op(mk(6'h12, 5'h0c, 5'd3, 5'd7), 0, 0, 1, 64'h0);
    do_op(mk(6'h12, 5'h0c, 5'd3, 5'd7) | 32'h0020_0000, 1, 0, 0, 64'h0);
    do_op(mk(6'h12, 5'h0c, 5'd3, 5'd7) ^ 32'h0400_0000, 1, 0, 0, 64'h0);
    do_op(mk(6'h16, 5'h05, 5'd3, 5'd7), 1, 0, 0, 64'h0);
    do_op(mk(6'h12, 5'h1c, 5'd3, 5'd7), 1, 0, 0, 64'h0);
    do_op(mk(6'h10, 5'h04, 5'd3, 5'd7), 1, 0, 0, 64'h0);
  endtask

  // Two issues on consecutive edges; both results must reach write-back, and the first one must reach the register file
  task automatic t_b2b();
    @(posedge mclk);
    issue_valid <= 1'b1;
    issue_instr <= mk(6'h12, 5'h07, 5'd3, 5'd20);
    @(posedge mclk);
    issue_instr <= mk(6'h16, 5'h04, 5'd3, 5'd21);
    #1;
    chk("b2b first valid", 64'h1, {63'h0, wb_valid_r});
    chk("b2b first data", {32'h0, q15(SRC_A[23:16]), q15(SRC_A[7:0])}, wb_data_r);
    @(posedge mclk);
    issue_valid <= 1'b0;
    #1;
    chk("b2b second valid", 64'h1, {63'h0, wb_valid_r});
    chk("b2b second data", {q15(SRC_A[63:56]), q15(SRC_A[55:48]), q15(SRC_A[47:40]),
        q15(SRC_A[39:32])}, wb_data_r);
    @(posedge mclk);
    #1;
    chk("b2b idle", 64'h0, {63'h0, wb_valid_r});
    chk("b2b rf write", {32'h0, q15(SRC_A[23:16]), q15(SRC_A[7:0])}, rf.mem[20]);
  endtask

  // ****************************************
  // Clock, main sequence and watchdog
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    rst         = 1'b1;
    issue_valid = 1'b0;
    issue_instr = 32'h0000_0000;
    ext_enable  = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_half();
    t_pair();
    t_quad();
    t_refuse();
    t_b2b();
    end_of_test();
  end

  // About 40 cycles of work; fifteen times that means a hang
  initial begin
    repeat (600) @(posedge mclk);
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    end_of_test();
  end
endmodule
